// *** verilog/lso_pkg.sv ***
// Shared constants for the link sync and over-range configuration block.
`default_nettype none

package lso_pkg;

	// ==========================================================
	// Register addresses on the serial register port.
	localparam logic [14:0] ADDR_SYNC_HEADER_SELECT = 15'h020f;
	localparam logic [14:0] ADDR_SYNC_REQUEST_THRESHOLD = 15'h0210;
	localparam logic [14:0] ADDR_OVERRANGE_LEVEL = 15'h0211;
	localparam logic [14:0] ADDR_OVERRANGE_CONFIG = 15'h0213;
	localparam logic [14:0] ADDR_INIT_PROGRESS_STATUS = 15'h0270;

	// ==========================================================
	// Field positions inside the 8-bit registers.
	localparam int SH_SELECT_LSB = 0;
	localparam int THRESH_LSB = 0;
	localparam int OVERRANGE_OUTPUT_ENABLE_BIT = 3;
	localparam int OVERRANGE_STRETCH_EXPONENT_LSB = 0;
	localparam int INIT_DONE_BIT = 0;

	// ==========================================================
	// Reset values of the stored fields.
	localparam logic [1:0] RST_SH_SELECT = 2'h0;
	localparam logic [4:0] RST_SYNC_REQUEST_THRESHOLD = 5'h03;
	localparam logic [7:0] RST_OVR_LEVEL = 8'hf2;
	localparam logic RST_OVERRANGE_OUTPUT_ENABLE = 1'b0;
	localparam logic [2:0] RST_OVERRANGE_STRETCH_EXPONENT = 3'h7;

	// ==========================================================
	// Sync-header content selections; codes 1 and 3 are reserved.
	localparam logic [1:0] SH_CRC = 2'h0;
	localparam logic [1:0] SH_FEC = 2'h2;

	// Layout of the 32-bit multiblock sync word; all other bits are idle command bits.
	localparam int SYNC_WORD_W = 32;
	localparam int CRC_W = 12;
	localparam int FEC_W = 26;
	localparam int CRC_LSB = 20;
	localparam int FEC_LSB = 6;

	// ==========================================================
	// Over-range stretch: the shortest pulse is STRETCH_BASE times two to the N.
	localparam int STRETCH_CNT_W = 10;
	localparam logic [STRETCH_CNT_W-1:0] STRETCH_BASE = 10'h004;
	localparam int OVR_LEVEL_W = 8;

	// ==========================================================
	// Serial frame: one read flag, fifteen address bits, eight data bits.
	localparam logic [4:0] SPI_HDR_LAST = 5'h0f;
	localparam logic [4:0] SPI_FRAME_LAST = 5'h17;

	// ==========================================================
	// Internal initialization time and its cycle count at 100 MHz.
	localparam int CLK_PERIOD_NS = 10;
	localparam int INIT_TIME_NS = 1000;
	localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : lso_pkg

`default_nettype wire

// *** verilog/lso_ovr_chan.sv ***
// One channel of over-range detection with a pulse stretcher.
`default_nettype none

module lso_ovr_chan
	import lso_pkg::*;
#(
	parameter int SAMPLE_W = 9
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sample_tick,
	input wire logic enable,
	input wire logic [SAMPLE_W-1:0] sample,
	input wire logic [OVR_LEVEL_W-1:0] level,
	input wire logic [2:0] stretch_n,
	output logic flag
);

	// ==========================================================
	// Elaboration check.
	// The level scales against a signed sample of at least nine bits.
	if (SAMPLE_W < 9) begin : g_bad_width
		$error("lso_ovr_chan: SAMPLE_W must be at least 9");
	end

	// ==========================================================
	// State.
	typedef struct packed {
		logic [STRETCH_CNT_W-1:0] cnt; // Sampling cycles left after the current one.
		logic flag; // Stretched over-range indication.
	} lso_chan_state_t;

	lso_chan_state_t st_r;
	lso_chan_state_t st_nxt;
	logic [SAMPLE_W-1:0] mag; // Absolute sample value.
	logic [SAMPLE_W-1:0] lvl_ext; // Level scaled to the sample's full scale.
	logic hit; // Detection in this sampling cycle.
	logic [STRETCH_CNT_W-1:0] period_m1; // Stretch length less one.

	// ==========================================================
	// Next-state logic.
	// The most negative code gives a magnitude of exactly full scale, which still fits unsigned.
	always_comb begin
		mag = sample[SAMPLE_W-1] ? SAMPLE_W'(-sample) : sample;
		lvl_ext = SAMPLE_W'({level, {(SAMPLE_W - 8){1'b0}}} >> 1);
		hit = sample_tick && enable && (mag >= lvl_ext);
		period_m1 = STRETCH_CNT_W'((STRETCH_BASE << stretch_n) - 1'b1);
		st_nxt = st_r;
		if (!enable) begin
			// Disabled channels drop any pending pulse.
			st_nxt.cnt = '0;
			st_nxt.flag = 1'b0;
		end else if (hit) begin
			// A new detection restarts the whole stretch period.
			st_nxt.cnt = period_m1;
			st_nxt.flag = 1'b1;
		end else if (sample_tick && st_r.flag) begin
			if (st_r.cnt == '0) begin
				st_nxt.flag = 1'b0;
			end else begin
				st_nxt.cnt = st_r.cnt - 1'b1;
			end
		end
	end

	// ==========================================================
	// State register.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign flag = st_r.flag;

	// ==========================================================
	// Checks.
	a_stretch_holds: assert property (@(posedge clk) disable iff (sys_rst)
		enable && st_r.flag && st_r.cnt != '0 |=> st_r.flag)
		else $error("over-range pulse ended before its stretch period");
	a_detect_restart: assert property (@(posedge clk) disable iff (sys_rst)
		hit |=> st_r.flag && st_r.cnt == $past(period_m1))
		else $error("detection did not restart the stretch count");
	a_own_channel: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(st_r.flag) |-> $past(hit))
		else $error("flag rose without a detection on this channel");

endmodule : lso_ovr_chan

`default_nettype wire

// *** verilog/lso_top.sv ***
// Link sync, sync-header and over-range configuration registers with serial port.
// Functional notes
// - Select 0 sends CRC-12, 2 sends FEC.
// - Select ignored unless link uses 64B/66B.
// - Sync word carries 12 CRC or 26 FEC bits of header data.
// - All command fields are sent as zero.
// - Sample SYNC~ on every link clock cycle.
// - Request after threshold-plus-one consecutive low samples.
// - Shorter lows are error reports, ignored.
// - Level sets magnitude that flags over-range.
// - Flag outputs held low unless enabled.
// - Pulse lasts at least four times two-to-N cycles.
// - Init status bit reads 1 once initialized.
`default_nettype none

module lso_top
	import lso_pkg::*;
#(
	parameter int SAMPLE_W = 9,
	parameter int INIT_WAIT = INIT_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	input wire logic sync_n,
	input wire logic sample_tick,
	input wire logic link_mode_64b66b,
	input wire logic [CRC_W-1:0] crc_value,
	input wire logic [FEC_W-1:0] fec_value,
	input wire logic [SAMPLE_W-1:0] sample_a,
	input wire logic [SAMPLE_W-1:0] sample_b,
	input wire logic [SAMPLE_W-1:0] sample_c,
	input wire logic [SAMPLE_W-1:0] sample_d,
	output logic sync_request,
	output logic [SYNC_WORD_W-1:0] sync_word,
	output logic overrange_flag_a,
	output logic overrange_flag_b,
	output logic overrange_flag_c,
	output logic overrange_flag_d
);

	// ==========================================================
	// Elaboration checks.
	if (INIT_WAIT < 1 || INIT_WAIT > 65535) begin : g_bad_init
		$error("lso_top: INIT_WAIT must lie in 1..65535");
	end

	// ==========================================================
	// State of the block, except the over-range channel stretchers, in one record.
	typedef struct packed {
		logic [2:0] sclk_s; // Serial clock synchroniser plus edge history.
		logic [1:0] cs_s; // Chip select synchroniser.
		logic [1:0] sdi_s; // Serial data synchroniser.
		logic [1:0] sync_s; // SYNC~ pin synchroniser.
		logic [4:0] bit_cnt; // Serial bits taken in this frame.
		logic [15:0] hdr; // Read flag and address.
		logic [6:0] dat; // Write data gathered so far.
		logic [7:0] out; // Read data still to be shifted out.
		logic sdo; // Serial data out.
		logic sdo_oe; // Serial data out enable.
		logic [1:0] sh_select; // Sync-header content selection.
		logic [4:0] thresh; // Sync request threshold.
		logic [7:0] level; // Over-range level.
		logic overrange_output_enable; // Over-range output enable.
		logic [2:0] overrange_stretch_exponent; // Over-range stretch exponent.
		logic [15:0] init_cnt; // Initialization timer.
		logic init_done; // Initialization finished.
		logic link_phase; // Divider from sample rate to link rate.
		logic [5:0] low_cnt; // Consecutive low SYNC~ samples, saturating.
		logic sync_req; // Synchronization request.
		logic [SYNC_WORD_W-1:0] sync_word; // Multiblock sync word.
		logic [3:0] flags; // Gated over-range outputs.
	} lso_top_state_t;

	localparam lso_top_state_t ST_RESET = '{
		sclk_s: 3'h0, cs_s: 2'h3, sdi_s: 2'h0, sync_s: 2'h3, bit_cnt: 5'h00,
		hdr: 16'h0000, dat: 7'h00, out: 8'h00, sdo: 1'b0, sdo_oe: 1'b0,
		sh_select: RST_SH_SELECT, thresh: RST_SYNC_REQUEST_THRESHOLD, level: RST_OVR_LEVEL,
		overrange_output_enable: RST_OVERRANGE_OUTPUT_ENABLE, overrange_stretch_exponent: RST_OVERRANGE_STRETCH_EXPONENT, init_cnt: 16'h0000, init_done: 1'b0,
		link_phase: 1'b0, low_cnt: 6'h00, sync_req: 1'b0, sync_word: 32'h0000_0000,
		flags: 4'h0};

	lso_top_state_t st_r;
	lso_top_state_t st_nxt;
	logic [SAMPLE_W-1:0] samples [4]; // Channel samples gathered for the generate loop.
	logic [3:0] chan_flag; // Stretched flags from the channels.
	logic sclk_rise; // Synchronised serial clock rising edge.
	logic sclk_fall; // Synchronised serial clock falling edge.
	logic cs_act; // Frame in progress.
	logic link_tick; // One cycle per link clock period.
	logic wr_commit; // Last bit of a write frame.
	logic [7:0] wr_data; // Complete write byte.
	logic [5:0] thresh_p1; // Threshold plus one.

	// ==========================================================
	// Register read decode. Unmapped addresses and reserved bits return zero.
	function automatic logic [7:0] reg_read(input logic [14:0] addr, input lso_top_state_t s);
		logic [7:0] v;
		v = 8'h00;
		unique case (addr)
			ADDR_SYNC_HEADER_SELECT: v[SH_SELECT_LSB +: 2] = s.sh_select;
			ADDR_SYNC_REQUEST_THRESHOLD: v[THRESH_LSB +: 5] = s.thresh;
			ADDR_OVERRANGE_LEVEL: v = s.level;
			ADDR_OVERRANGE_CONFIG: begin
				v[OVERRANGE_OUTPUT_ENABLE_BIT] = s.overrange_output_enable;
				v[OVERRANGE_STRETCH_EXPONENT_LSB +: 3] = s.overrange_stretch_exponent;
			end
			ADDR_INIT_PROGRESS_STATUS: v[INIT_DONE_BIT] = s.init_done;
			default: v = 8'h00;
		endcase
		return v;
	endfunction : reg_read

	// ==========================================================
	// Over-range channels.
	assign samples[0] = sample_a;
	assign samples[1] = sample_b;
	assign samples[2] = sample_c;
	assign samples[3] = sample_d;

	for (genvar i = 0; i < 4; i++) begin : g_chan
		lso_ovr_chan #(.SAMPLE_W(SAMPLE_W)) u_chan (
			.clk(clk),
			.sys_rst(sys_rst),
			.sample_tick(sample_tick),
			.enable(st_r.overrange_output_enable),
			.sample(samples[i]),
			.level(st_r.level),
			.stretch_n(st_r.overrange_stretch_exponent),
			.flag(chan_flag[i])
		);
	end

	// ==========================================================
	// Next-state logic.
	// The serial pins are slow compared to clk, so edges are found on synchronised copies;
	// the serial clock must stay below about a quarter of clk for this to hold.
	always_comb begin
		st_nxt = st_r;
		st_nxt.sclk_s = {st_r.sclk_s[1:0], spi_sclk};
		st_nxt.cs_s = {st_r.cs_s[0], spi_cs_n};
		st_nxt.sdi_s = {st_r.sdi_s[0], spi_sdi};
		st_nxt.sync_s = {st_r.sync_s[0], sync_n};
		sclk_rise = st_r.sclk_s[1] && !st_r.sclk_s[2];
		sclk_fall = !st_r.sclk_s[1] && st_r.sclk_s[2];
		cs_act = !st_r.cs_s[1];
		wr_data = {st_r.dat, st_r.sdi_s[1]};
		wr_commit = cs_act && sclk_rise && st_r.bit_cnt == SPI_FRAME_LAST && !st_r.hdr[15];

		// Serial frame handling.
		if (!cs_act) begin
			st_nxt.bit_cnt = 5'h00;
			st_nxt.sdo_oe = 1'b0;
		end else if (sclk_rise) begin
			if (st_r.bit_cnt <= SPI_HDR_LAST) begin
				st_nxt.hdr = {st_r.hdr[14:0], st_r.sdi_s[1]};
			end else begin
				st_nxt.dat = wr_data[6:0];
			end
			if (st_r.bit_cnt == SPI_HDR_LAST) begin
				// Header complete: fetch read data before the first data bit.
				st_nxt.out = reg_read({st_r.hdr[13:0], st_r.sdi_s[1]}, st_r);
			end
			// The count stops one past the last bit, so extra clocks cannot commit twice.
			if (st_r.bit_cnt <= SPI_FRAME_LAST) begin
				st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
			end
		end else if (sclk_fall && st_r.bit_cnt > SPI_HDR_LAST && st_r.hdr[15]) begin
			st_nxt.sdo = st_r.out[7];
			st_nxt.out = {st_r.out[6:0], 1'b0};
			st_nxt.sdo_oe = 1'b1;
		end

		// Register writes; only the defined fields are stored.
		if (wr_commit) begin
			unique case (st_r.hdr[14:0])
				ADDR_SYNC_HEADER_SELECT: st_nxt.sh_select = wr_data[SH_SELECT_LSB +: 2];
				ADDR_SYNC_REQUEST_THRESHOLD: st_nxt.thresh = wr_data[THRESH_LSB +: 5];
				ADDR_OVERRANGE_LEVEL: st_nxt.level = wr_data;
				ADDR_OVERRANGE_CONFIG: begin
					st_nxt.overrange_output_enable = wr_data[OVERRANGE_OUTPUT_ENABLE_BIT];
					st_nxt.overrange_stretch_exponent = wr_data[OVERRANGE_STRETCH_EXPONENT_LSB +: 3];
				end
				default: st_nxt.level = st_r.level;
			endcase
		end

		// Initialization timer; the done bit never falls until reset.
		if (!st_r.init_done) begin
			st_nxt.init_cnt = st_r.init_cnt + 16'h0001;
			st_nxt.init_done = (st_r.init_cnt == 16'(INIT_WAIT - 1));
		end

		// Link clock runs at half the sample rate.
		link_tick = sample_tick && st_r.link_phase;
		if (sample_tick) begin
			st_nxt.link_phase = !st_r.link_phase;
		end

		// SYNC~ filter: count consecutive low samples at the link rate.
		thresh_p1 = {1'b0, st_r.thresh} + 6'h01;
		if (link_tick) begin
			if (st_r.sync_s[1]) begin
				// A high sample ends the run; a short run was only an error report.
				st_nxt.low_cnt = 6'h00;
				st_nxt.sync_req = 1'b0;
			end else begin
				if (st_r.low_cnt != 6'h3f) begin
					st_nxt.low_cnt = st_r.low_cnt + 6'h01;
				end
				// Compare the saturated count, so a long low never wraps and drops the request.
				st_nxt.sync_req = st_nxt.low_cnt >= thresh_p1;
			end
		end

		// Sync word: selection applies only in 64B/66B modes; command bits stay idle.
		st_nxt.sync_word = '0;
		if (link_mode_64b66b) begin
			unique case (st_r.sh_select)
				SH_CRC: st_nxt.sync_word[CRC_LSB +: CRC_W] = crc_value;
				SH_FEC: st_nxt.sync_word[FEC_LSB +: FEC_W] = fec_value;
				default: st_nxt.sync_word = '0;
			endcase
		end

		// Over-range outputs forced low while disabled.
		st_nxt.flags = st_r.overrange_output_enable ? chan_flag : 4'h0;
	end

	// ==========================================================
	// State register.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= ST_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs, all straight from the state register.
	assign spi_sdo = st_r.sdo;
	assign spi_sdo_oe = st_r.sdo_oe;
	assign sync_request = st_r.sync_req;
	assign sync_word = st_r.sync_word;
	assign overrange_flag_a = st_r.flags[0];
	assign overrange_flag_b = st_r.flags[1];
	assign overrange_flag_c = st_r.flags[2];
	assign overrange_flag_d = st_r.flags[3];

	// ==========================================================
	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_low_tick;
		link_tick && !st_r.sync_s[1];
	endsequence

	sequence s_write_level;
		wr_commit && st_r.hdr[14:0] == ADDR_OVERRANGE_LEVEL;
	endsequence

	a_sh_ignored_8b10b: assert property (!link_mode_64b66b |=> sync_word == '0)
		else $error("sync word not idle outside 64B/66B mode");
	a_sh_crc_content: assert property (
		link_mode_64b66b && st_r.sh_select == SH_CRC
		|=> sync_word[CRC_LSB +: CRC_W] == $past(crc_value) && sync_word[CRC_LSB-1:0] == '0)
		else $error("CRC sync word content wrong");
	a_sh_fec_cmd_zero: assert property (
		link_mode_64b66b && st_r.sh_select == SH_FEC
		|=> sync_word[FEC_LSB +: FEC_W] == $past(fec_value) && sync_word[FEC_LSB-1:0] == '0)
		else $error("FEC sync word content or command bits wrong");
	a_request_needs_run: assert property (sync_request |-> st_r.low_cnt >= thresh_p1)
		else $error("sync request without enough low samples");
	a_short_low_ignored: assert property (st_r.low_cnt < thresh_p1 |-> !sync_request)
		else $error("short SYNC low raised a request");
	a_fast_request: assert property (s_low_tick and st_r.thresh == 5'h00 |=> sync_request)
		else $error("zero threshold did not give an immediate request");
	a_sync_high_clears: assert property (
		link_tick && st_r.sync_s[1] |=> st_r.low_cnt == 6'h00 && !sync_request)
		else $error("high SYNC sample did not end the low run");
	a_level_write: assert property (s_write_level |=> st_r.level == $past(wr_data))
		else $error("over-range level write lost");
	a_flags_off: assert property (!st_r.overrange_output_enable |=> st_r.flags == 4'h0)
		else $error("over-range flags not held low while disabled");
	a_init_sticky: assert property (
		st_r.init_done |=> st_r.init_done ##1 st_r.init_done)
		else $error("init done fell");

endmodule : lso_top

`default_nettype wire

// *** verification/lso_rx_model.sv ***
// Behavioural far-end receiver that drives the link resynchronisation line.
`default_nettype none

module lso_rx_model (
	input wire logic clk,
	input wire logic sample_tick,
	input wire logic go,
	input wire logic [5:0] low_len,
	output logic sync_n
);
	// ==========
	// Burst timing
	// Sample ticks left while the line is held low; two ticks make one link cycle.
	logic [6:0] left_r = 7'h00;

	// A burst is only sent on command, so no stray error reports reach the device.
	always_ff @(posedge clk) begin
		if (go) begin
			left_r <= {low_len, 1'b0};
		end else if (sample_tick && left_r != 7'h00) begin
			left_r <= left_r - 7'h01;
		end
	end

	// The line rests high; it is low only while a burst runs.
	assign sync_n = (left_r == 7'h00);
endmodule : lso_rx_model

`default_nettype wire

// *** verification/link_sync_overrange_cfg_tb.sv ***
// Self-checking bench for the link sync and over-range configuration block.
`default_nettype none

module link_sync_overrange_cfg_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lso_pkg::*;

	// ==========
	// Stimulus and observation signals
	logic clk = 1'b0, sys_rst = 1'b1, sclk = 1'b0, cs_n = 1'b1, sdi = 1'b0;
	logic tick = 1'b0, mode = 1'b0, go = 1'b0, obs_v = 1'b0;
	logic [5:0] low_len = 6'h00;
	logic [1:0] tcnt = 2'h0;
	logic [CRC_W-1:0] crc = '0;
	logic [FEC_W-1:0] fec = '0;
	logic [8:0] sa = '0, sb = '0, sc = '0, sd = '0;
	logic sdo, sdo_oe, sync_n, req, fa, fb, fc, fd, hit;
	logic [31:0] word, obs_d = '0, e;
	logic [7:0] lvl;
	logic oe_seen = 1'b0; // Data-out enable as seen during the last data bit of a frame.
	logic [31:0] exp_q[$];
	string nm_q[$];
	int miscompares = 0, cmp_count = 0, cycles = 0;
	int th[3] = '{3, 0, 31};

	always #5 clk = ~clk;

	// Sampling cycles come every fourth clock, so a link cycle spans eight clocks.
	always @(posedge clk) begin
		tcnt <= tcnt + 2'h1;
		tick <= (tcnt == 2'h3);
	end

	lso_top #(.SAMPLE_W(9), .INIT_WAIT(5)) i_lso_top (
		.clk(clk), .sys_rst(sys_rst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi),
		.spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .sync_n(sync_n), .sample_tick(tick),
		.link_mode_64b66b(mode), .crc_value(crc), .fec_value(fec), .sample_a(sa),
		.sample_b(sb), .sample_c(sc), .sample_d(sd), .sync_request(req), .sync_word(word),
		.overrange_flag_a(fa), .overrange_flag_b(fb), .overrange_flag_c(fc),
		.overrange_flag_d(fd)
	);

	lso_rx_model i_lso_rx_model (
		.clk(clk), .sample_tick(tick), .go(go), .low_len(low_len), .sync_n(sync_n)
	);

	// ==========
	// Reporting
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
		cmp_count++;
		if (s !== x) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, x, s);
		end
	endtask : check

	task automatic end_of_test();
		$display("Compares %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	// The watcher pairs each observed result with the oldest noted expectation.
	always @(posedge clk) begin
		if (obs_v === 1'b1) check(nm_q.pop_front(), obs_d, exp_q.pop_front());
	end

	// A hang is cut short well above the expected run of about six and a half thousand cycles.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			miscompares++;
			end_of_test();
		end
	end

	// Notes the expectation, then hands the seen value over; two edges keep strobes apart.
	task automatic ex(input string n, input logic [31:0] s, input logic [31:0] x);
		nm_q.push_back(n);
		exp_q.push_back(x);
		obs_d <= s;
		obs_v <= 1'b1;
		@(posedge clk);
		obs_v <= 1'b0;
		@(posedge clk);
	endtask : ex

	// ==========
	// Serial register port: 24 bits, most significant first, five clocks per half period.
	task automatic spi(input logic rw, input logic [14:0] a, input logic [7:0] d,
			output logic [7:0] q);
		logic [23:0] f;
		f = {rw, a, d};
		q = 8'h00;
		cs_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdi <= f[i];
			repeat (5) @(posedge clk);
			sclk <= 1'b1;
			repeat (5) @(posedge clk);
			if (i < 8) q[i] = sdo;
			if (i == 0) oe_seen = sdo_oe;
			sclk <= 1'b0;
		end
		repeat (5) @(posedge clk);
		cs_n <= 1'b1;
		// The data line is not left at its last bit, so a stale level cannot pass.
		sdi <= ~f[0];
		repeat (8) @(posedge clk);
	endtask : spi

	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		logic [7:0] q;
		spi(1'b0, a, d, q);
		// A write frame never turns the data-out driver on.
		ex("write drive idle", {30'h0, oe_seen, sdo_oe}, 32'h0);
	endtask : wr

	task automatic rd(input string n, input logic [14:0] a, input logic [7:0] x);
		logic [7:0] q;
		spi(1'b1, a, 8'h00, q);
		// The driver is on during the data bits and off again once the frame has ended.
		ex("read drive", {30'h0, oe_seen, sdo_oe}, 32'h2);
		ex(n, {24'h0, q}, {24'h0, x});
	endtask : rd

	// Starts a burst just after a sampling tick, so every low tick is counted.
	task automatic burst(input int n, output logic h);
		h = 1'b0;
		do @(posedge clk); while (tick !== 1'b1);
		low_len <= 6'(n);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (8 * n + 40) begin
			@(posedge clk);
			h = h | req;
		end
	endtask : burst

	// Presents one set of samples for exactly one sampling tick.
	task automatic drive(input logic [8:0] a, b, c, d);
		do @(posedge clk); while (tick !== 1'b1);
		sa <= a;
		sb <= b;
		sc <= c;
		sd <= d;
		repeat (4) @(posedge clk);
		sa <= 9'h000;
		sb <= 9'h000;
		sc <= 9'h000;
		sd <= 9'h000;
	endtask : drive

	// ==========
	// Main sequence
	initial begin
		void'($urandom(32'h200e5c75));
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		// The host waits for initialisation before its first frame.
		repeat (20) @(posedge clk);
		rd("init status", ADDR_INIT_PROGRESS_STATUS, 8'h01);
		rd("select", ADDR_SYNC_HEADER_SELECT, 8'h00);
		rd("threshold", ADDR_SYNC_REQUEST_THRESHOLD, 8'h03);
		rd("level", ADDR_OVERRANGE_LEVEL, 8'hf2);
		rd("config", ADDR_OVERRANGE_CONFIG, 8'h07);
		rd("unmapped", 15'h0212, 8'h00);
		wr(ADDR_INIT_PROGRESS_STATUS, 8'h00);
		rd("status after write", ADDR_INIT_PROGRESS_STATUS, 8'h01);
		$display("test registers done");

		// Every link mode against every select code, reserved codes included.
		for (int m = 0; m < 2; m++) begin
			for (int s = 0; s < 4; s++) begin
				wr(ADDR_SYNC_HEADER_SELECT, 8'(s));
				crc <= 12'($urandom);
				fec <= 26'($urandom);
				mode <= m[0];
				repeat (3) @(posedge clk);
				e = (m == 0 || s[0]) ? 32'h0 : (s == 0) ? {crc, 20'h0} : {fec, 6'h0};
				ex("sync_word", word, e);
			end
		end
		$display("test sync word done");

		// A burst as long as the threshold is ignored; threshold plus one requests.
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_SYNC_REQUEST_THRESHOLD, 8'(th[i]));
			if (th[i] > 0) begin
				burst(th[i], hit);
				ex("short low", {31'h0, hit}, 32'h0);
			end
			burst(th[i] + 1, hit);
			ex("long low", {31'h0, hit}, 32'h1);
			ex("request released", {31'h0, req}, 32'h0);
		end
		$display("test sync request done");

		// Stretch exponent 1 gives eight sampling ticks, thirty-two clocks.
		lvl = 8'($urandom_range(255, 1));
		wr(ADDR_OVERRANGE_CONFIG, 8'h09);
		wr(ADDR_OVERRANGE_LEVEL, lvl);
		drive({1'b0, lvl}, {1'b0, lvl} - 9'h001, -{1'b0, lvl}, {2'b00, lvl[7:1]});
		repeat (20) @(posedge clk);
		ex("flags", {28'h0, fa, fb, fc, fd}, 32'ha);
		drive({1'b0, lvl}, 9'h000, 9'h000, 9'h000);
		repeat (24) @(posedge clk);
		ex("flags restarted", {28'h0, fa, fb, fc, fd}, 32'h8);
		// A steady detection keeps the flag up until the outputs are disabled.
		sa <= {1'b0, lvl};
		repeat (8) @(posedge clk);
		ex("flags steady", {28'h0, fa, fb, fc, fd}, 32'h8);
		wr(ADDR_OVERRANGE_CONFIG, 8'h01);
		repeat (4) @(posedge clk);
		ex("flags disabled", {28'h0, fa, fb, fc, fd}, 32'h0);
		sa <= 9'h000;
		$display("test over-range done");
		repeat (4) @(posedge clk);
		end_of_test();
	end
endmodule : link_sync_overrange_cfg_tb

`default_nettype wire
